// file: include/uart_ctl_pkg.sv
// Package with register offsets, field positions, reset values and codes for the UART control block.
package uart_ctl_pkg;
    localparam logic [2:0] OFF_DATA = 3'h0;
    localparam logic [2:0] OFF_MASK = 3'h1;
    localparam logic [2:0] OFF_SOURCE_FIFO = 3'h2;
    localparam logic [2:0] OFF_FORMAT = 3'h3;
    localparam logic [2:0] OFF_ENHANCED = 3'h4;
    localparam logic [2:0] OFF_LINE_STATUS = 3'h5;
    localparam logic [2:0] OFF_MODEM_STATUS = 3'h6;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] FORMAT_RESET = 8'h00;
    localparam logic [7:0] ENHANCED_RESET = 8'h00;
    localparam int ENH_GATE_BIT = 4;
    localparam int ENH_AUTO_RTS_BIT = 6;
    localparam int ENH_AUTO_CTS_BIT = 7;
    localparam logic [5:0] CODE_LINE = 6'h06;
    localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
    localparam logic [5:0] CODE_RX_READY = 6'h04;
    localparam logic [5:0] CODE_TX_READY = 6'h02;
    localparam logic [5:0] CODE_MODEM = 6'h00;
    localparam logic [5:0] CODE_PAUSE = 6'h10;
    localparam logic [5:0] CODE_FLOW = 6'h20;
    localparam logic [5:0] CODE_NONE = 6'h01;
    localparam logic [5:0] TX_TRIG_00 = 6'h10;
    localparam logic [5:0] TX_TRIG_01 = 6'h08;
    localparam logic [5:0] TX_TRIG_10 = 6'h18;
    localparam logic [5:0] TX_TRIG_11 = 6'h1E;
    localparam logic [5:0] RX_TRIG_00 = 6'h08;
    localparam logic [5:0] RX_TRIG_01 = 6'h10;
    localparam logic [5:0] RX_TRIG_10 = 6'h18;
    localparam logic [5:0] RX_TRIG_11 = 6'h1E;
    localparam logic [3:0] DATA_BITS_MIN = 4'h5;
    localparam logic [4:0] TIMEOUT_EXTRA_BITS = 5'h0C;
    localparam logic [3:0] TIMEOUT_CHARS = 4'h4;

    // Register port request.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    // Events reported by the data path of the channel.
    typedef struct packed {
        logic [3:0] line_errors;
        logic [3:0] modem_deltas;
        logic pause_seen;
        logic resume_seen;
        logic special_seen;
        logic char_received;
        logic bit_tick;
    } line_events_type;

    // Character format decoded from the line format register.
    typedef struct packed {
        logic [3:0] data_bits;
        logic [1:0] stop_halves;
    } char_format_type;
endpackage : uart_ctl_pkg

// file: logic/uart_trigger_level.sv
// Trigger level decode and trigger comparison for one FIFO direction.
`timescale 1ns/1ns
module uart_trigger_level
    import uart_ctl_pkg::*;
#(
    parameter int COUNT_W = 6
)
(
    input wire logic [1:0] code,
    input wire logic is_tx,
    input wire logic [COUNT_W-1:0] count,
    output logic [COUNT_W-1:0] level,
    output logic at_or_above
);
    initial
    begin
        if (COUNT_W < 5)
        begin
            $error("COUNT_W too small for trigger 30.");
        end
    end

    // Maps the two-bit code to the documented level for the direction.
    function automatic logic [5:0] decode(input logic [1:0] c, input logic tx);
        logic [5:0] r;
        r = 6'h00;
        case (c)
            2'h0: r = tx ? TX_TRIG_00 : RX_TRIG_00;
            2'h1: r = tx ? TX_TRIG_01 : RX_TRIG_01;
            2'h2: r = tx ? TX_TRIG_10 : RX_TRIG_10;
            default: r = tx ? TX_TRIG_11 : RX_TRIG_11;
        endcase
        return r;
    endfunction : decode

    // Level and comparison are purely combinational.
    assign level = COUNT_W'(decode(code, is_tx));
    assign at_or_above = count >= level;
endmodule : uart_trigger_level

// file: logic/uart_rx_timeout.sv
// Receive timeout timer counting four characters plus twelve bit times.
`timescale 1ns/1ns
module uart_rx_timeout
    import uart_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic bit_tick,
    input wire logic restart,
    input wire logic armed,
    input wire logic [3:0] bits_per_char,
    output logic expired
);
    logic [6:0] limit;
    logic [6:0] count_q;

    // Four frames of start, data and one stop bit plus twelve bits.
    assign limit = 7'(TIMEOUT_CHARS * (bits_per_char + 4'h2)) + 7'(TIMEOUT_EXTRA_BITS);

    // Counts bit times while data waits; restarts on any receive activity.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_q <= 7'h00;
            expired <= 1'b0;
        end
        else if (ce)
        begin
            if (restart || !armed)
            begin
                count_q <= 7'h00;
                expired <= 1'b0;
            end
            else if (bit_tick && !expired)
            begin
                count_q <= count_q + 7'h01;
                expired <= (count_q + 7'h01) >= limit;
            end
        end
    end
endmodule : uart_rx_timeout

// file: logic/uart_ctl.sv
// Interrupt, FIFO control and line format logic for one UART channel.
// What this block does
// - Enabled, gated: rising request-to-send under auto flow control raises an interrupt.
// - Enabled, gated: rising clear-to-send under auto flow control raises an interrupt.
// - Source read shows highest pending; lower ones stay queued.
// - Codes: line 06h, timeout 0Ch, receive ready 04h, transmit ready 02h.
// - Codes: modem 00h, pause/special 10h, flow 20h, none 01h at reset.
// - Timeout after four characters plus twelve bits; receive data read clears it.
// - Line status bits 1 to 4 raise line interrupt; line status read clears.
// - Receive trigger raises receive ready; clears when count drops below trigger.
// - Transmit trigger or empty raises transmit ready; source read or data write clears.
// - Modem status bits 0 to 3 raise modem interrupt; modem status read clears.
// - Pause character raises interrupt; source read or resume character clears.
// - Special character raises interrupt; source read or next character clears.
// - Flow-control transition interrupts clear on modem status read.
// - Source bit 0 low when pending; bits 7:6 high when FIFOs enabled.
// - FIFO control bit 0 enables FIFOs; other bits need bit 0 in same write.
// - Reset bits 1 and 2 clear that FIFO's pointers, then self-clear.
// - FIFO control bit 3 selects DMA mode for the ready pins.
// - Transmit trigger 16, 8, 24, 30; fires below trigger or on empty.
// - Receive trigger 8, 16, 24, 30; fires when count crosses the level.
// - Line format bits 1:0 give 5 to 8 data bits, 5 by default.
// - Bit 2 gives one stop bit, or 1.5 for 5 bits, else 2.
// - Enhanced bit 4 gates mask 7:4, source 5:4, transmit trigger 5:4.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module uart_ctl
    import uart_ctl_pkg::*;
#(
    parameter int COUNT_W = 6
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire reg_req_type req,
    output logic [7:0] rdata,
    input wire line_events_type events,
    input wire logic [COUNT_W-1:0] rx_count,
    input wire logic [COUNT_W-1:0] tx_count,
    input wire logic rts_pin_n,
    input wire logic cts_pin_n,
    output logic irq,
    output logic rx_fifo_reset,
    output logic tx_fifo_reset,
    output logic fifo_enable,
    output logic dma_mode,
    output logic transmit_dma_request_n,
    output logic receive_dma_request_n,
    output char_format_type char_format,
    output logic [7:0] line_format_out
);
    initial
    begin
        if (COUNT_W < 5 || COUNT_W > 8)
        begin
            $error("COUNT_W must lie between 5 and 8.");
        end
    end

    logic [7:0] interrupt_mask_q;
    logic [7:0] line_format_q;
    logic [7:0] enhanced_feature_q;
    logic [1:0] rx_trig_q;
    logic [1:0] tx_trig_q;
    logic line_pend_q;
    logic modem_pend_q;
    logic tx_pend_q;
    logic pause_pend_q;
    logic special_pend_q;
    logic special_wait_q;
    logic flow_pend_q;
    logic rts_high_q;
    logic cts_high_q;
    logic tx_above_q;
    logic tx_event_q;
    logic gate;
    logic rd_source;
    logic rd_data;
    logic rd_line;
    logic rd_modem;
    logic wr_data;
    logic wr_fifo;
    logic rx_at_trig;
    logic tx_at_trig;
    logic timeout_hit;
    logic tx_event;
    logic rts_rise;
    logic cts_rise;
    logic [5:0] code;
    logic [7:0] rdata_d;
    logic [COUNT_W-1:0] rx_level;
    logic [COUNT_W-1:0] tx_level;

    // Strobe decode.
    assign gate = enhanced_feature_q[ENH_GATE_BIT];
    assign rd_source = req.rd && req.addr == OFF_SOURCE_FIFO;
    assign rd_data = req.rd && req.addr == OFF_DATA;
    assign rd_line = req.rd && req.addr == OFF_LINE_STATUS;
    assign rd_modem = req.rd && req.addr == OFF_MODEM_STATUS;
    assign wr_data = req.wr && req.addr == OFF_DATA;
    assign wr_fifo = req.wr && req.addr == OFF_SOURCE_FIFO;

    uart_trigger_level #(.COUNT_W(COUNT_W)) rx_trig_u (
        .code(rx_trig_q),
        .is_tx(1'b0),
        .count(rx_count),
        .level(rx_level),
        .at_or_above(rx_at_trig)
    );

    uart_trigger_level #(.COUNT_W(COUNT_W)) tx_trig_u (
        .code(tx_trig_q),
        .is_tx(1'b1),
        .count(tx_count),
        .level(tx_level),
        .at_or_above(tx_at_trig)
    );

    uart_rx_timeout timeout_u (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .bit_tick(events.bit_tick),
        .restart(events.char_received || rd_data),
        .armed(rx_count != '0 && fifo_enable),
        .bits_per_char(char_format.data_bits),
        .expired(timeout_hit)
    );

    // Mask, format and enhanced registers; gated mask bits keep their value.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            interrupt_mask_q <= MASK_RESET;
            line_format_q <= FORMAT_RESET;
            enhanced_feature_q <= ENHANCED_RESET;
        end
        else if (ce && req.wr)
        begin
            if (req.addr == OFF_MASK)
            begin
                interrupt_mask_q[3:0] <= req.wdata[3:0];
                if (gate)
                begin
                    interrupt_mask_q[7:4] <= req.wdata[7:4];
                end
            end
            if (req.addr == OFF_FORMAT)
            begin
                line_format_q <= req.wdata;
            end
            if (req.addr == OFF_ENHANCED)
            begin
                enhanced_feature_q <= req.wdata;
            end
        end
    end

    // FIFO control write; other fields only take effect with bit 0 set.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifo_enable <= 1'b0;
            dma_mode <= 1'b0;
            rx_trig_q <= 2'h0;
            tx_trig_q <= 2'h0;
            rx_fifo_reset <= 1'b0;
            tx_fifo_reset <= 1'b0;
        end
        else if (ce)
        begin
            rx_fifo_reset <= 1'b0;
            tx_fifo_reset <= 1'b0;
            if (wr_fifo)
            begin
                fifo_enable <= req.wdata[0];
                if (req.wdata[0])
                begin
                    dma_mode <= req.wdata[3];
                    rx_trig_q <= req.wdata[7:6];
                    rx_fifo_reset <= req.wdata[1];
                    tx_fifo_reset <= req.wdata[2];
                    if (gate)
                    begin
                        tx_trig_q <= req.wdata[5:4];
                    end
                end
            end
        end
    end

    // Transmit ready condition: below trigger after a reload above it, otherwise empty.
    assign tx_event = (fifo_enable && tx_above_q) ? !tx_at_trig : tx_count == '0;

    // Tracks whether the last reload pushed the count above the trigger.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_above_q <= 1'b0;
            tx_event_q <= 1'b0;
        end
        else if (ce)
        begin
            if (tx_count > tx_level)
            begin
                tx_above_q <= 1'b1;
            end
            else if (tx_count == '0)
            begin
                tx_above_q <= 1'b0;
            end
            tx_event_q <= tx_event; // History so that only a new condition raises the flag.
        end
    end

    // Flow-control pin history for rising-edge detection.
    assign rts_rise = !rts_high_q && rts_pin_n;
    assign cts_rise = !cts_high_q && cts_pin_n;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rts_high_q <= 1'b1;
            cts_high_q <= 1'b1;
        end
        else if (ce)
        begin
            rts_high_q <= rts_pin_n;
            cts_high_q <= cts_pin_n;
        end
    end

    // Sticky pending flags; a set in the same cycle as its clear wins.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_pend_q <= 1'b0;
            modem_pend_q <= 1'b0;
            tx_pend_q <= 1'b0;
            pause_pend_q <= 1'b0;
            special_pend_q <= 1'b0;
            special_wait_q <= 1'b0;
            flow_pend_q <= 1'b0;
        end
        else if (ce)
        begin
            if (|events.line_errors)
            begin
                line_pend_q <= 1'b1;
            end
            else if (rd_line)
            begin
                line_pend_q <= 1'b0;
            end
            if (|events.modem_deltas)
            begin
                modem_pend_q <= 1'b1;
            end
            else if (rd_modem)
            begin
                modem_pend_q <= 1'b0;
            end
            if (tx_event && !tx_event_q)
            begin
                tx_pend_q <= 1'b1;
            end
            else if ((rd_source && code == CODE_TX_READY) || wr_data)
            begin
                tx_pend_q <= 1'b0;
            end
            if (events.pause_seen)
            begin
                pause_pend_q <= 1'b1;
            end
            else if ((rd_source && code == CODE_PAUSE) || events.resume_seen)
            begin
                pause_pend_q <= 1'b0;
            end
            if (events.special_seen)
            begin
                special_pend_q <= 1'b1;
                special_wait_q <= 1'b1;
            end
            else if ((rd_source && code == CODE_PAUSE)
                     || (special_wait_q && events.char_received))
            begin
                special_pend_q <= 1'b0;
                special_wait_q <= 1'b0;
            end
            if ((rts_rise && enhanced_feature_q[ENH_AUTO_RTS_BIT] && interrupt_mask_q[6])
                || (cts_rise && enhanced_feature_q[ENH_AUTO_CTS_BIT] && interrupt_mask_q[7]))
            begin
                flow_pend_q <= 1'b1;
            end
            else if (rd_modem)
            begin
                flow_pend_q <= 1'b0;
            end
        end
    end

    // Priority encoder over enabled sources, highest level first.
    always_comb
    begin
        code = CODE_NONE;
        if (interrupt_mask_q[2] && line_pend_q)
        begin
            code = CODE_LINE;
        end
        else if (interrupt_mask_q[0] && timeout_hit)
        begin
            code = CODE_TIMEOUT;
        end
        else if (interrupt_mask_q[0] && (fifo_enable ? rx_at_trig : rx_count != '0))
        begin
            code = CODE_RX_READY;
        end
        else if (interrupt_mask_q[1] && tx_pend_q)
        begin
            code = CODE_TX_READY;
        end
        else if (interrupt_mask_q[3] && modem_pend_q)
        begin
            code = CODE_MODEM;
        end
        else if (gate && interrupt_mask_q[5] && (pause_pend_q || special_pend_q))
        begin
            code = CODE_PAUSE;
        end
        else if (gate && (|interrupt_mask_q[7:6]) && flow_pend_q)
        begin
            code = CODE_FLOW;
        end
    end

    // Read mux; the source register reports FIFO status in bits 7:6.
    always_comb
    begin
        rdata_d = 8'h00;
        case (req.addr)
            OFF_MASK: rdata_d = interrupt_mask_q;
            OFF_SOURCE_FIFO: rdata_d = {{2{fifo_enable}}, code};
            OFF_FORMAT: rdata_d = line_format_q;
            OFF_ENHANCED: rdata_d = enhanced_feature_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Registered outputs.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata <= 8'h00;
            irq <= 1'b0;
            transmit_dma_request_n <= 1'b1;
            receive_dma_request_n <= 1'b1;
            char_format <= '{data_bits: DATA_BITS_MIN, stop_halves: 2'h2};
            line_format_out <= FORMAT_RESET;
        end
        else if (ce)
        begin
            rdata <= req.rd ? rdata_d : 8'h00;
            irq <= code != CODE_NONE;
            transmit_dma_request_n <= dma_mode ? tx_at_trig : tx_count != '0;
            receive_dma_request_n <= dma_mode ? !(rx_at_trig || timeout_hit) : rx_count == '0;
            char_format.data_bits <= DATA_BITS_MIN + {2'h0, line_format_q[1:0]};
            char_format.stop_halves <= !line_format_q[2] ? 2'h2
                                     : (line_format_q[1:0] == 2'h0 ? 2'h3 : 2'h0);
            line_format_out <= line_format_q;
        end
    end

    // Assertions.
    property p_irq_follows;
        @(posedge clk) disable iff (!rst_n) ce |=> (irq == ($past(code) != CODE_NONE));
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("irq wrong.");
    property p_fifo_rst_pulse;
        @(posedge clk) disable iff (!rst_n) rx_fifo_reset && ce |=> !rx_fifo_reset;
    endproperty
    a_fifo_rst_pulse: assert property (p_fifo_rst_pulse) else $error("reset stuck.");
    property p_no_fifo_gate;
        @(posedge clk) disable iff (!rst_n) ce && wr_fifo && !req.wdata[0] |=>
            !rx_fifo_reset && !tx_fifo_reset && $stable(dma_mode);
    endproperty
    a_no_fifo_gate: assert property (p_no_fifo_gate) else $error("FIFO bits taken.");
    property p_line_prio;
        @(posedge clk) disable iff (!rst_n) interrupt_mask_q[2] && line_pend_q |-> code == CODE_LINE;
    endproperty
    a_line_prio: assert property (p_line_prio) else $error("line not top.");
    property p_line_clear;
        @(posedge clk) disable iff (!rst_n) ce && rd_line && !(|events.line_errors) |=> !line_pend_q;
    endproperty
    a_line_clear: assert property (p_line_clear) else $error("line not cleared.");
    property p_flow_clear;
        @(posedge clk) disable iff (!rst_n) ce && rd_modem && !rts_rise && !cts_rise |=> !flow_pend_q;
    endproperty
    a_flow_clear: assert property (p_flow_clear) else $error("flow not cleared.");
    property p_fifo_bits;
        @(posedge clk) disable iff (!rst_n) ce && rd_source |=> rdata[7:6] == {2{$past(fifo_enable)}};
    endproperty
    a_fifo_bits: assert property (p_fifo_bits) else $error("status bits wrong.");
    property p_none_code;
        @(posedge clk) disable iff (!rst_n) code == CODE_NONE |-> !(line_pend_q && interrupt_mask_q[2]);
    endproperty
    a_none_code: assert property (p_none_code) else $error("pending hidden.");
    c_line: cover property (@(posedge clk) disable iff (!rst_n) code == CODE_LINE);
    c_flow: cover property (@(posedge clk) disable iff (!rst_n) code == CODE_FLOW);
    c_timeout: cover property (@(posedge clk) disable iff (!rst_n) code == CODE_TIMEOUT);
endmodule : uart_ctl

// file: verif/host_bus_model.sv
// Host processor model that drives the register port of the channel.
`timescale 1ns/1ns
module host_bus_model
    import uart_ctl_pkg::*;
(
    input wire logic clk,
    output reg_req_type req
);
    initial req = '0;

    // One write cycle; callers set the enable bit beside other control bits, except the 0Eh write that checks the gating.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : wr

    // One read cycle; the data are taken by the watcher in the following cycle.
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    endtask : rd
endmodule : host_bus_model

// file: verif/tb_uart_interrupt_fifo_line_control.sv
// Self-checking bench for the channel interrupt, FIFO control and line format logic.
`timescale 1ns/1ns
module tb_uart_interrupt_fifo_line_control
    import uart_ctl_pkg::*;
;
    logic clk, rst_n, rts_pin_n, cts_pin_n, irq, rx_fifo_reset, tx_fifo_reset;
    logic fifo_enable, dma_mode, tdr_n, rdr_n;
    logic rd_p = 1'b0;
    reg_req_type req;
    line_events_type events;
    logic [5:0] rx_count, tx_count;
    logic [7:0] rdata, lf_out, v;
    logic [5:0] lvl[4] = '{6'h08, 6'h10, 6'h18, 6'h1E};
    char_format_type char_format;
    logic [15:0] notes[$];
    logic [15:0] note;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    host_bus_model u_host (.clk(clk), .req(req));

    uart_ctl u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .req(req), .rdata(rdata),
        .events(events), .rx_count(rx_count), .tx_count(tx_count), .rts_pin_n(rts_pin_n),
        .cts_pin_n(cts_pin_n), .irq(irq), .rx_fifo_reset(rx_fifo_reset),
        .tx_fifo_reset(tx_fifo_reset), .fifo_enable(fifo_enable), .dma_mode(dma_mode),
        .transmit_dma_request_n(tdr_n), .receive_dma_request_n(rdr_n),
        .char_format(char_format), .line_format_out(lf_out));

    // Clock generator.
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Prints the verdict and ends the run.
    task automatic tally_and_finish();
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    // Compares one value and reports a mismatch.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Notes the expected read data with a care mask, then reads.
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        notes.push_back({m, e});
        u_host.rd(a);
    endtask : rd_chk

    // Watches read data one cycle after each read strobe and bounds the run.
    always @(posedge clk)
    begin
        rd_p <= req.rd;
        cycles <= cycles + 1;
        if (rd_p && notes.size() > 0)
        begin
            note = notes.pop_front();
            chk(rdata & note[15:8], note[7:0]);
        end
        if (cycles == 3000)
        begin
            failures++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial
    begin
        rst_n = 1'b0;
        rts_pin_n = 1'b0;
        cts_pin_n = 1'b0;
        events = '0;
        tx_count = 6'h10;
        rx_count = 6'h00;
        void'($urandom(49));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({2'b00, char_format}, 8'h16);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b00, CODE_NONE});
        for (int i = 0; i < 8; i++)
        begin
            v = {1'b0, 4'($urandom), i[2:0]};
            u_host.wr(OFF_FORMAT, v);
            @(posedge clk);
            #1;
            chk(lf_out, v);
            chk({2'b00, char_format}, {2'b00, DATA_BITS_MIN + i[1:0],
                !i[2] ? 2'h2 : (i[1:0] == 2'b00 ? 2'h3 : 2'h0)});
            rd_chk(OFF_FORMAT, 8'hFF, v);
        end
        u_host.wr(OFF_SOURCE_FIFO, 8'h01);
        u_host.wr(OFF_SOURCE_FIFO, 8'h07);
        #1;
        chk({5'h00, rx_fifo_reset, tx_fifo_reset, fifo_enable}, 8'h07);
        @(posedge clk);
        #1;
        chk({5'h00, rx_fifo_reset, tx_fifo_reset, fifo_enable}, 8'h01);
        u_host.wr(OFF_SOURCE_FIFO, 8'h0E);
        #1;
        chk({4'h0, dma_mode, rx_fifo_reset, tx_fifo_reset, fifo_enable}, 8'h00);
        u_host.wr(OFF_SOURCE_FIFO, 8'h09);
        #1;
        chk({6'h00, dma_mode, fifo_enable}, 8'h03);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
        rx_count <= 6'($urandom % 8);
        events.line_errors <= 4'h1 + 4'($urandom % 15);
        events.modem_deltas <= 4'h1 + 4'($urandom % 15);
        u_host.wr(OFF_MASK, 8'h0D);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h01);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_LINE});
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_LINE});
        events.line_errors <= 4'h0;
        rd_chk(OFF_LINE_STATUS, 8'hFF, 8'h00);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_MODEM});
        events.modem_deltas <= 4'h0;
        rd_chk(OFF_MODEM_STATUS, 8'hFF, 8'h00);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
        for (int c = 0; c < 4; c++)
        begin
            u_host.wr(OFF_SOURCE_FIFO, {c[1:0], 6'h01});
            rx_count <= lvl[c] - 6'h01;
            rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
            rx_count <= lvl[c];
            rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_RX_READY});
            #1;
            chk({6'h00, tdr_n, rdr_n}, 8'h02);
        end
        rx_count <= 6'h00;
        u_host.wr(OFF_MASK, 8'hC0);
        cts_pin_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
        cts_pin_n <= 1'b0;
        u_host.wr(OFF_ENHANCED, 8'hD0);
        u_host.wr(OFF_MASK, 8'hC0);
        cts_pin_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h01);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_FLOW});
        rd_chk(OFF_MODEM_STATUS, 8'hFF, 8'h00);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
        rts_pin_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_FLOW});
        rd_chk(OFF_MODEM_STATUS, 8'hFF, 8'h00);
        repeat (3) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h00);
        u_host.wr(OFF_SOURCE_FIFO, 8'h11);
        u_host.wr(OFF_MASK, 8'h02);
        tx_count <= 6'h07;
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_TX_READY});
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
        tx_count <= 6'h00;
        repeat (2) @(posedge clk);
        tx_count <= 6'h05;
        repeat (2) @(posedge clk);
        tx_count <= 6'h00;
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, 8'h01);
        u_host.wr(OFF_DATA, 8'h5A);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
        rx_count <= 6'h01;
        events.bit_tick <= 1'b1;
        u_host.wr(OFF_MASK, 8'h01);
        repeat (40) @(posedge clk);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
        repeat (20) @(posedge clk);
        events.bit_tick <= 1'b0;
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_TIMEOUT});
        rd_chk(OFF_DATA, 8'hFF, 8'h00);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
        u_host.wr(OFF_MASK, 8'h20);
        events.pause_seen <= 1'b1;
        @(posedge clk);
        events.pause_seen <= 1'b0;
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_PAUSE});
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
        events.special_seen <= 1'b1;
        @(posedge clk);
        events.special_seen <= 1'b0;
        events.char_received <= 1'b1;
        @(posedge clk);
        events.char_received <= 1'b0;
        #1;
        chk({7'h00, irq}, 8'h01);
        rd_chk(OFF_SOURCE_FIFO, 8'hFF, {2'b11, CODE_NONE});
        repeat (3) @(posedge clk);
        tally_and_finish();
    end
endmodule : tb_uart_interrupt_fifo_line_control
